// *** cwd_defs.svh ***
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH

// location and reach of the configuration word
`define CWD_CFG_ADDR        14'h2007
`define CWD_TEST_LO         14'h2000
`define CWD_TEST_HI         14'h3fff
`define CWD_CFG_ERASED      14'h3fff

// field positions within the word
`define CWD_CP_HI_MSB       13
`define CWD_CP_HI_LSB       12
`define CWD_BORV_MSB        11
`define CWD_BORV_LSB        10
`define CWD_CP_MID_MSB      9
`define CWD_CP_MID_LSB      8
`define CWD_UNIMPL_BIT      7
`define CWD_BROWNOUT_ENABLE_BIT_BIT       6
`define CWD_CP_LO_MSB       5
`define CWD_CP_LO_LSB       4
`define CWD_POWERUP_DELAY_ENABLE_N_BIT       3
`define CWD_WATCHDOG_ENABLE_BIT_BIT        2
`define CWD_FOSC_MSB        1
`define CWD_FOSC_LSB        0

// protected ranges
`define CWD_PROT_END        12'hfff
`define CWD_PROT_HALF       12'h800
`define CWD_PROT_QTR        12'h400
`define CWD_PROT_ALL        12'h000

// timing
`define CWD_CLK_NS          10
`define CWD_POWERUP_DELAY_TIMER_MS         72
`define CWD_POWERUP_DELAY_TIMER_CYC        ((`CWD_POWERUP_DELAY_TIMER_MS * 1000000) / `CWD_CLK_NS)
`define CWD_OST_EDGES       11'h400

`endif

// *** cwd_pkg.sv ***
package cwd_pkg;

   typedef enum logic [1:0] {
      CWD_OSC_LP = 2'b00,
      CWD_OSC_XT = 2'b01,
      CWD_OSC_HS = 2'b10,
      CWD_OSC_RC = 2'b11
   } cwd_osc_t;

   typedef enum logic [1:0] {
      CWD_BOR_4V5 = 2'b00,
      CWD_BOR_4V2 = 2'b01,
      CWD_BOR_2V7 = 2'b10,
      CWD_BOR_2V5 = 2'b11
   } cwd_trip_t;

   typedef struct packed {
      logic [1:0] code_protect_sel;
      logic       protect_on;
      logic [11:0] protect_lo;
      cwd_trip_t  brownout_trip_sel;
      logic       brownout_enable_bit;
      logic       powerup_delay_enable_n;
      logic       powerup_delay_active;
      logic       watchdog_enable_bit;
      cwd_osc_t   clock_source_sel;
      logic       crystal_mode;
      logic       ext_clock_ok;
   } cwd_opts_t;

   typedef enum logic [2:0] {
      CWD_ST_LOAD  = 3'b000,
      CWD_ST_BOR   = 3'b001,
      CWD_ST_POWERUP_DELAY_TIMER  = 3'b010,
      CWD_ST_OST   = 3'b011,
      CWD_ST_RUN   = 3'b100,
      CWD_ST_SLEEP = 3'b101
   } cwd_state_t;

endpackage

// *** cwd_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cwd_defs.svh"

module cwd_decode (
   input  wire logic [13:0]       cfg_word,
   output cwd_pkg::cwd_opts_t     opts
);

   // programmed bits read 0, so decodes treat 1 as the unprogrammed default
   function automatic logic [11:0] prot_base(input logic [1:0] sel);
      case (sel)
         2'b10:   prot_base = `CWD_PROT_HALF;
         2'b01:   prot_base = `CWD_PROT_QTR;
         default: prot_base = `CWD_PROT_ALL;
      endcase
   endfunction

   logic [1:0] cp_hi;
   logic [1:0] cp_mid;
   logic [1:0] cp_lo;

   assign cp_hi  = cfg_word[`CWD_CP_HI_MSB:`CWD_CP_HI_LSB];
   assign cp_mid = cfg_word[`CWD_CP_MID_MSB:`CWD_CP_MID_LSB];
   assign cp_lo  = cfg_word[`CWD_CP_LO_MSB:`CWD_CP_LO_LSB];

   always_comb begin
      opts.code_protect_sel = cp_hi;
      // RULE4: protect range decode
      // RULE5: only matching pairs take effect
      opts.protect_on = (cp_hi == cp_mid) && (cp_hi == cp_lo) && (cp_hi != 2'b11);
      opts.protect_lo = prot_base(cp_hi);
      // RULE6: trip level select
      opts.brownout_trip_sel = cwd_pkg::cwd_trip_t'(cfg_word[`CWD_BORV_MSB:`CWD_BORV_LSB]);
      // RULE8: brown-out enable
      opts.brownout_enable_bit = cfg_word[`CWD_BROWNOUT_ENABLE_BIT_BIT];
      // RULE9: power-up timer active low
      opts.powerup_delay_enable_n = cfg_word[`CWD_POWERUP_DELAY_ENABLE_N_BIT];
      // RULE12: brown-out forces timer
      opts.powerup_delay_active = ~cfg_word[`CWD_POWERUP_DELAY_ENABLE_N_BIT] | cfg_word[`CWD_BROWNOUT_ENABLE_BIT_BIT];
      // RULE10: watchdog enable
      opts.watchdog_enable_bit = cfg_word[`CWD_WATCHDOG_ENABLE_BIT_BIT];
      // RULE11: oscillator mode
      opts.clock_source_sel = cwd_pkg::cwd_osc_t'(cfg_word[`CWD_FOSC_MSB:`CWD_FOSC_LSB]);
      opts.crystal_mode = (opts.clock_source_sel != cwd_pkg::CWD_OSC_RC);
      // RULE17: external clock only in fast crystal mode
      opts.ext_clock_ok = (opts.clock_source_sel == cwd_pkg::CWD_OSC_HS);
   end

endmodule // cwd_decode
`default_nettype wire

// *** cwd_ost.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cwd_defs.svh"

module cwd_ost (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic osc_sync,
   output logic      done
);

   logic [10:0] cnt_q;
   logic        prev_q;
   logic        run_q;

   // rising edges of the synchronised oscillator input are counted
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= osc_sync;
      end
   end

   // RULE18: count oscillator edges
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 11'h000;
         run_q <= 1'b0;
      end else if (start) begin
         cnt_q <= 11'h000;
         run_q <= 1'b1;
      end else if (run_q && osc_sync && !prev_q) begin
         cnt_q <= cnt_q + 11'h001;
         if (cnt_q == `CWD_OST_EDGES - 11'h001) begin
            run_q <= 1'b0;
         end
      end
   end

   assign done = !run_q && (cnt_q == `CWD_OST_EDGES);

endmodule // cwd_ost
`default_nettype wire

// *** cwd_top.sv ***
// Summary of operation
// RULE1: configuration bits read 0 when programmed, 1 when unprogrammed.
// RULE2: configuration word lives at program address 2007h.
// RULE3: 2000h to 3FFFh reachable only in programming mode.
// RULE4: protect field 11 none, 10 upper half, 01 upper three quarters, 00 all.
// RULE5: programmer writes all three protect pairs alike for protection to apply.
// RULE6: bits 11-10 pick brown-out trip 2.5, 2.7, 4.2 or 4.5 volts.
// RULE7: bit 7 unimplemented, always reads 1.
// RULE8: bit 6 set enables brown-out reset, clear disables it.
// RULE9: bit 3 low enables power-up timer, high disables it.
// RULE10: watchdog enable bit set runs watchdog, clear stops it.
// RULE11: bits 1-0 select RC, HS, XT or LP oscillator.
// RULE12: brown-out enabled forces power-up timer on.
// RULE13: watchdog off only by configuration, clocked by own oscillator. The code also holds watchdog_run low in CWD_ST_LOAD.
// RULE14: power-on and brown-out resets hold reset for 72 ms.
// RULE15: start-up timer holds reset until crystal is stable.
// RULE16: sleep ends on external reset, watchdog wake-up or interrupt.
// RULE17: external clock accepted only in high-speed crystal mode.
// RULE18: start-up timer counts 1024 input cycles after power-up delay.
// RULE19: start-up delay only in crystal modes after power-up or wake.
// RULE20: brown-out during power-up delay restarts the full delay.
// RULE21: options latched at reset, held constant during operation.
`timescale 1ns/100ps
`default_nettype none
`include "cwd_defs.svh"

module cwd_top #(
   parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `CWD_POWERUP_DELAY_TIMER_CYC
) (
   input  wire logic               clock,
   input  wire logic               resetn,
   input  wire logic               prog_mode,
   input  wire logic [13:0]        prog_addr,
   input  wire logic               prog_wr,
   input  wire logic [13:0]        prog_wdata,
   input  wire logic               prog_rd,
   output logic      [13:0]        prog_rdata,
   output logic                    prog_ack,
   input  wire logic [13:0]        cpu_addr,
   output logic                    cpu_test_space,
   input  wire logic               por_event,
   input  wire logic               mclr_event,
   input  wire logic               brownout_low,
   input  wire logic               wdt_timeout,
   input  wire logic               irq_wake,
   input  wire logic               sleep_req,
   input  wire logic               clock_in_pin,
   input  wire logic               wdt_rc_clk,
   output logic                    chip_reset,
   output logic                    sleeping,
   output logic                    brownout_reset,
   output logic                    watchdog_run,
   output logic                    watchdog_clk,
   output logic                    ext_clock_en,
   output logic                    brownout_detect_en,
   output cwd_pkg::cwd_trip_t      brownout_trip_voltage,
   output cwd_pkg::cwd_osc_t       clock_source_sel,
   output logic                    code_protect_on,
   output logic      [11:0]        protect_lo,
   output logic      [11:0]        protect_hi
);

   // ------------------------------------------------------------
   // reset release and input synchronisers
   // ------------------------------------------------------------
   logic       rst_meta_q;
   logic       rst_n;
   logic [1:0] osc_s_q;
   logic [1:0] bo_s_q;
   logic [1:0] wdt_s_q;
   logic [1:0] irq_s_q;
   logic [1:0] mclr_s_q;
   logic [1:0] por_s_q;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // pins from the analog side: second stage only is read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         osc_s_q  <= 2'b00;
         bo_s_q   <= 2'b00;
         wdt_s_q  <= 2'b00;
         irq_s_q  <= 2'b00;
         mclr_s_q <= 2'b00;
         por_s_q  <= 2'b00;
      end else begin
         osc_s_q  <= {osc_s_q[0], clock_in_pin};
         bo_s_q   <= {bo_s_q[0], brownout_low};
         wdt_s_q  <= {wdt_s_q[0], wdt_timeout};
         irq_s_q  <= {irq_s_q[0], irq_wake};
         mclr_s_q <= {mclr_s_q[0], mclr_event};
         por_s_q  <= {por_s_q[0], por_event};
      end
   end

   // ------------------------------------------------------------
   // configuration word store
   // ------------------------------------------------------------
   logic [13:0] cfg_q;
   logic        in_test;
   logic        cfg_hit;

   function automatic logic test_space(input logic [13:0] a);
      test_space = (a >= `CWD_TEST_LO) && (a <= `CWD_TEST_HI);
   endfunction

   assign in_test = test_space(prog_addr);
   // RULE2: word at fixed address
   assign cfg_hit = prog_mode && (prog_addr == `CWD_CFG_ADDR);

   // RULE1: erased word reads all ones
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= `CWD_CFG_ERASED;
      end else if (cfg_hit && prog_wr) begin
         // RULE7: unimplemented bit stuck at one
         cfg_q <= prog_wdata | (14'h0001 << `CWD_UNIMPL_BIT);
      end
   end

   // RULE3: test space only in programming mode
   assign cpu_test_space = prog_mode && test_space(cpu_addr);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prog_rdata <= 14'h0000;
         prog_ack   <= 1'b0;
      end else begin
         prog_ack <= prog_mode && in_test && (prog_rd || prog_wr);
         if (cfg_hit && prog_rd) begin
            // RULE7: bit reads one
            prog_rdata <= cfg_q | (14'h0001 << `CWD_UNIMPL_BIT);
         end else if (prog_rd) begin
            prog_rdata <= `CWD_CFG_ERASED;
         end
      end
   end

   // ------------------------------------------------------------
   // option decode and latching
   // ------------------------------------------------------------
   cwd_pkg::cwd_opts_t opts_now;
   cwd_pkg::cwd_opts_t opts_q;
   cwd_pkg::cwd_state_t state_q;

   cwd_decode u_decode (
      .cfg_word (cfg_q),
      .opts     (opts_now)
   );

   // RULE21: capture options only while in reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         opts_q <= '0;
      end else if (state_q == cwd_pkg::CWD_ST_LOAD) begin
         opts_q <= opts_now;
      end
   end

   assign code_protect_on       = opts_q.protect_on;
   assign protect_lo            = opts_q.protect_lo;
   assign protect_hi            = `CWD_PROT_END;
   assign brownout_trip_voltage = opts_q.brownout_trip_sel;
   assign clock_source_sel      = opts_q.clock_source_sel;
   assign brownout_detect_en    = opts_q.brownout_enable_bit;
   // RULE17: external clock gate
   assign ext_clock_en          = opts_q.ext_clock_ok;
   // RULE13: no run-time stop of watchdog, own clock
   assign watchdog_run          = opts_q.watchdog_enable_bit && (state_q != cwd_pkg::CWD_ST_LOAD);
   assign watchdog_clk          = wdt_rc_clk;

   // ------------------------------------------------------------
   // reset sequencer
   // ------------------------------------------------------------
   logic [23:0] powerup_delay_timer_q;
   logic        ost_start;
   logic        ost_done;
   logic        powerup_q;
   logic        bo_act;
   logic        por_s;
   logic        powerup_delay_timer_done;

   assign bo_act    = opts_q.brownout_enable_bit && bo_s_q[1];
   assign por_s     = por_s_q[1];
   assign powerup_delay_timer_done = (powerup_delay_timer_q == 24'h000000);

   cwd_ost u_ost (
      .clock    (clock),
      .rst_n    (rst_n),
      .start    (ost_start),
      .osc_sync (osc_s_q[1]),
      .done     (ost_done)
   );

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= cwd_pkg::CWD_ST_LOAD;
         powerup_delay_timer_q    <= 24'h000000;
         powerup_q <= 1'b1;
         ost_start <= 1'b0;
      end else begin
         ost_start <= 1'b0;
         if (por_s) begin
            state_q   <= cwd_pkg::CWD_ST_LOAD;
            powerup_q <= 1'b1;
         end else if (bo_act) begin
            // RULE20: brown-out restarts delay
            state_q   <= cwd_pkg::CWD_ST_BOR;
            powerup_q <= 1'b1;
         end else if (mclr_s_q[1]) begin
            state_q   <= cwd_pkg::CWD_ST_LOAD;
            powerup_q <= 1'b0;
         end else begin
            case (state_q)
               cwd_pkg::CWD_ST_LOAD, cwd_pkg::CWD_ST_BOR: begin
                  // RULE14: 72 ms only on power-up resets
                  // RULE12: forced under brown-out
                  if (powerup_q && (opts_now.powerup_delay_active ||
                                    state_q == cwd_pkg::CWD_ST_BOR)) begin
                     powerup_delay_timer_q  <= POWERUP_DELAY_TIMER_CYCLES[23:0];
                     state_q <= cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER;
                  end else if (powerup_q && opts_now.crystal_mode) begin
                     ost_start <= 1'b1;
                     state_q   <= cwd_pkg::CWD_ST_OST;
                  end else begin
                     state_q <= cwd_pkg::CWD_ST_RUN;
                  end
               end
               cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER: begin
                  if (!powerup_delay_timer_done) begin
                     powerup_delay_timer_q <= powerup_delay_timer_q - 24'h000001;
                  // RULE18: start-up timer after the delay
                  // RULE19: crystal modes only
                  end else if (opts_q.crystal_mode) begin
                     ost_start <= 1'b1;
                     state_q   <= cwd_pkg::CWD_ST_OST;
                  end else begin
                     state_q <= cwd_pkg::CWD_ST_RUN;
                  end
               end
               cwd_pkg::CWD_ST_OST: begin
                  // RULE15: hold until oscillator stable
                  if (ost_done && !ost_start) begin
                     state_q   <= cwd_pkg::CWD_ST_RUN;
                     powerup_q <= 1'b0;
                  end
               end
               cwd_pkg::CWD_ST_RUN: begin
                  powerup_q <= 1'b0;
                  if (sleep_req) begin
                     state_q <= cwd_pkg::CWD_ST_SLEEP;
                  end
               end
               cwd_pkg::CWD_ST_SLEEP: begin
                  // RULE16: wake sources
                  if ((wdt_s_q[1] && opts_q.watchdog_enable_bit) || irq_s_q[1]) begin
                     if (opts_q.crystal_mode) begin
                        // RULE19: wake-up runs start-up timer
                        ost_start <= 1'b1;
                        state_q   <= cwd_pkg::CWD_ST_OST;
                     end else begin
                        state_q <= cwd_pkg::CWD_ST_RUN;
                     end
                  end
               end
               default: state_q <= cwd_pkg::CWD_ST_LOAD;
            endcase
         end
      end
   end

   assign chip_reset     = (state_q != cwd_pkg::CWD_ST_RUN) && (state_q != cwd_pkg::CWD_ST_SLEEP);
   assign sleeping       = (state_q == cwd_pkg::CWD_ST_SLEEP);
   assign brownout_reset = (state_q == cwd_pkg::CWD_ST_BOR);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   opts_stable_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE21
      (state_q == cwd_pkg::CWD_ST_RUN && $past(state_q) == cwd_pkg::CWD_ST_RUN)
      |-> $stable(opts_q))
      else $error("options changed during operation");

   unimpl_bit_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
      cfg_q[`CWD_UNIMPL_BIT] == 1'b1)
      else $error("unimplemented bit not one");

   test_space_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
      !prog_mode |-> !cpu_test_space)
      else $error("test space reachable outside programming");

   forced_powerup_delay_timer_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE12
      (state_q == cwd_pkg::CWD_ST_BOR && !bo_act && !por_s && !mclr_s_q[1])
      |=> state_q == cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER)
      else $error("brown-out recovery skipped power-up delay");

   ost_after_powerup_delay_timer_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
      (state_q == cwd_pkg::CWD_ST_OST && $past(state_q) != cwd_pkg::CWD_ST_OST
       && $past(state_q) == cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER) |-> $past(powerup_delay_timer_done))
      else $error("start-up timer began before delay ended");

   rc_no_ost_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE19
      (state_q == cwd_pkg::CWD_ST_OST) |-> opts_q.crystal_mode)
      else $error("start-up timer in rc mode");

   ext_clk_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
      ext_clock_en |-> (opts_q.clock_source_sel == cwd_pkg::CWD_OSC_HS))
      else $error("external clock outside fast crystal mode");

   reset_held_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
      (state_q == cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER) |-> chip_reset)
      else $error("reset released during power-up delay");

   powerup_delay_timer_full_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
      (state_q == cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER && $past(state_q) != cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER)
      |-> (powerup_delay_timer_q == POWERUP_DELAY_TIMER_CYCLES[23:0]))
      else $error("power-up delay did not start full");

   mclr_skip_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
      (state_q == cwd_pkg::CWD_ST_LOAD && !powerup_q && !por_s && !bo_act && !mclr_s_q[1])
      |=> (state_q == cwd_pkg::CWD_ST_RUN))
      else $error("timers ran after a non power-up reset");

   powerup_delay_timer_off_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
      (state_q == cwd_pkg::CWD_ST_LOAD && cfg_q[`CWD_POWERUP_DELAY_ENABLE_N_BIT] && !cfg_q[`CWD_BROWNOUT_ENABLE_BIT_BIT]
       && !por_s && !bo_act && !mclr_s_q[1]) |=> (state_q != cwd_pkg::CWD_ST_POWERUP_DELAY_TIMER))
      else $error("power-up delay ran while disabled");

   sleep_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
      (sleeping && !por_s && !bo_act && !mclr_s_q[1] && !irq_s_q[1]
       && !(wdt_s_q[1] && opts_q.watchdog_enable_bit)) |=> sleeping)
      else $error("sleep left without a wake source");

endmodule // cwd_top
`default_nettype wire

// *** cwd_prog_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// programmer model, one access per call
// ----------------------------------------
module cwd_prog_model (
   input  wire logic        clock,
   input  wire logic [13:0] prog_rdata,
   input  wire logic        prog_ack,
   output var  logic        prog_mode,
   output var  logic [13:0] prog_addr,
   output var  logic        prog_wr,
   output var  logic [13:0] prog_wdata,
   output var  logic        prog_rd
);
   initial begin
      prog_mode = 1'b0;
      prog_addr = 14'h0;
      prog_wr = 1'b0;
      prog_wdata = 14'h0;
      prog_rd = 1'b0;
   end
   task automatic set_mode(input logic m);
      @(posedge clock);
      prog_mode <= m;
   endtask
   task automatic access(input logic wr, input logic [13:0] a, input logic [13:0] d,
                         output logic [13:0] r, output logic ok);
      ok = 1'b0;
      r = 14'h0;
      @(posedge clock);
      prog_addr <= a;
      prog_wdata <= d;
      prog_wr <= wr;
      prog_rd <= ~wr;
      // request stands until the acknowledge is sampled high, for at most four clocks
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clock);
         if (prog_ack === 1'b1) begin
            ok = 1'b1;
            r = prog_rdata;
         end
      end
      prog_wr <= 1'b0;
      prog_rd <= 1'b0;
      // released lines must not look like a held value
      prog_addr <= ~a;
      prog_wdata <= ~d;
   endtask
endmodule // cwd_prog_model
`default_nettype wire

// *** cwd_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic               clock = 1'b0;
   logic               resetn = 1'b0;
   logic [13:0]        prog_addr, prog_wdata, prog_rdata;
   logic [13:0]        cpu_addr;
   logic               prog_mode, prog_wr, prog_rd, prog_ack, cpu_test_space;
   logic               por_event, mclr_event, brownout_low;
   logic               wdt_timeout, irq_wake, sleep_req;
   logic               clock_in_pin = 1'b0, wdt_rc_clk = 1'b0;
   logic               chip_reset, sleeping, brownout_reset, watchdog_run;
   logic               watchdog_clk, ext_clock_en, brownout_detect_en, code_protect_on;
   cwd_pkg::cwd_trip_t brownout_trip_voltage;
   cwd_pkg::cwd_osc_t  clock_source_sel;
   logic [11:0]        protect_lo, protect_hi;
   logic [1:0]         osc_div = 2'h0;
   int                 n_errors = 0, checks = 0, cyc = 0;

   always #5 clock = ~clock;
   // crystal input runs free at a quarter of the clock
   always @(posedge clock) begin
      osc_div <= osc_div + 2'h1;
      wdt_rc_clk <= osc_div[1];
      if (osc_div[0])
         clock_in_pin <= ~clock_in_pin;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         wrap_up();
      end
   end

   cwd_prog_model prog (.clock, .prog_rdata, .prog_ack, .prog_mode, .prog_addr, .prog_wr,
                        .prog_wdata, .prog_rd);
   cwd_top #(.POWERUP_DELAY_TIMER_CYCLES(20)) DUT (.clock, .resetn, .prog_mode, .prog_addr, .prog_wr,
      .prog_wdata, .prog_rd, .prog_rdata, .prog_ack, .cpu_addr, .cpu_test_space,
      .por_event, .mclr_event, .brownout_low, .wdt_timeout, .irq_wake, .sleep_req,
      .clock_in_pin, .wdt_rc_clk, .chip_reset, .sleeping, .brownout_reset, .watchdog_run,
      .watchdog_clk, .ext_clock_en, .brownout_detect_en, .brownout_trip_voltage,
      .clock_source_sel, .code_protect_on, .protect_lo, .protect_hi);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wait_rst(output int n);
      n = 0;
      while (chip_reset !== 1'b0 && n < 5000) begin
         @(posedge clock);
         n++;
      end
   endtask
   // held past the sync delay so reset is seen before counting
   task automatic load(input logic [13:0] w, input logic por, output int n);
      logic [13:0] r;
      logic        a;
      prog.set_mode(1'b1);
      prog.access(1'b1, 14'h2007, w, r, a);
      prog.set_mode(1'b0);
      if (por)
         por_event <= 1'b1;
      else
         mclr_event <= 1'b1;
      repeat (5) @(posedge clock);
      por_event <= 1'b0;
      mclr_event <= 1'b0;
      wait_rst(n);
   endtask
   task automatic doze();
      sleep_req <= 1'b1;
      repeat (4) @(posedge clock);
      sleep_req <= 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_prog();
      logic [13:0] r;
      logic        a;
      prog.set_mode(1'b1);
      prog.access(1'b1, 14'h2007, 14'h0000, r, a);
      chk(a, 1);
      prog.access(1'b0, 14'h2007, 14'h0000, r, a);
      chk(r, 14'h0080);
      prog.access(1'b1, 14'h2001, 14'h0000, r, a);
      prog.access(1'b0, 14'h2001, 14'h0000, r, a);
      chk(r, 14'h3fff);
      cpu_addr <= 14'h2007;
      @(posedge clock);
      #1 chk(cpu_test_space, 1);
      cpu_addr <= 14'h0100;
      @(posedge clock);
      #1 chk(cpu_test_space, 0);
      prog.set_mode(1'b0);
      cpu_addr <= 14'h2007;
      @(posedge clock);
      #1 chk(cpu_test_space, 0);
      prog.access(1'b0, 14'h2007, 14'h0000, r, a);
      chk(a, 0);
   endtask
   task automatic t_decode();
      logic [1:0] v;
      int         n;
      for (int i = 0; i < 4; i++) begin
         v = i[1:0];
         load({v, v, v, 1'b1, 1'b0, v, 1'b1, v[0], v}, 1'b0, n);
         chk(n < 40, 1);
         chk(brownout_trip_voltage, v);
         chk(clock_source_sel, v);
         chk(code_protect_on, v != 2'b11);
         if (v != 2'b11)
            chk(protect_lo, (v == 2'b10) ? 12'h800 : (v == 2'b01) ? 12'h400 : 12'h000);
         chk(protect_hi, 12'hfff);
         chk(watchdog_run, v[0]);
         chk(ext_clock_en, v == 2'b10);
         chk(brownout_detect_en, 0);
      end
      load(14'h1fff, 1'b0, n);
      chk(code_protect_on, 0);
   endtask
   task automatic t_timers();
      logic [13:0] w [5] = '{14'h3fb3, 14'h3fbf, 14'h3fff, 14'h3fb1, 14'h3fbe};
      int          lo [5] = '{20, 0, 20, 4096, 4096};
      int          hi [5] = '{45, 15, 45, 4250, 4250};
      int          n;
      for (int i = 0; i < 5; i++) begin
         load(w[i], 1'b1, n);
         chk(n >= lo[i] && n <= hi[i], 1);
      end
   endtask
   task automatic t_brown();
      int n;
      load(14'h3fff, 1'b0, n);
      brownout_low <= 1'b1;
      repeat (6) @(posedge clock);
      chk(brownout_reset, 1);
      chk(chip_reset, 1);
      chk(brownout_detect_en, 1);
      brownout_low <= 1'b0;
      repeat (10) @(posedge clock);
      brownout_low <= 1'b1;
      repeat (6) @(posedge clock);
      chk(brownout_reset, 1);
      brownout_low <= 1'b0;
      repeat (4) @(posedge clock);
      wait_rst(n);
      chk(n >= 15 && n <= 45, 1);
   endtask
   task automatic t_sleep();
      logic [13:0] r;
      logic        a;
      int          n;
      load(14'h3fff, 1'b0, n);
      doze();
      chk(sleeping, 1);
      wdt_timeout <= 1'b1;
      repeat (8) @(posedge clock);
      wdt_timeout <= 1'b0;
      chk(sleeping, 0);
      load(14'h3ffa, 1'b0, n);
      doze();
      wdt_timeout <= 1'b1;
      repeat (8) @(posedge clock);
      wdt_timeout <= 1'b0;
      chk(sleeping, 1);
      irq_wake <= 1'b1;
      repeat (8) @(posedge clock);
      irq_wake <= 1'b0;
      chk(sleeping, 0);
      chk(chip_reset, 1);
      chk(watchdog_clk, wdt_rc_clk);
      prog.set_mode(1'b1);
      prog.access(1'b1, 14'h2007, 14'h0000, r, a);
      chk(clock_source_sel, 2'b10);
   endtask

   initial begin
      cpu_addr <= 14'h0000;
      {por_event, mclr_event, brownout_low} <= 3'b000;
      {wdt_timeout, irq_wake, sleep_req} <= 3'b000;
      repeat (6) @(posedge clock);
      chk(watchdog_run, 0);
      resetn <= 1'b1;
      repeat (4) @(posedge clock);
      t_prog();
      t_decode();
      t_timers();
      t_brown();
      t_sleep();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
